// *** design/cfa_core.sv ***
// Condition flags, interrupt mask gating and operand address forming.
// Assumes one instruction per op_valid pulse and AXI4-Lite register access.
//
// Behaviour
// - Overflow flag tracks two's complement overflow
// - Signed branches include overflow in condition
// - Half carry from bit 3 on adds
// - Decimal adjust corrects using half carry, carry
// - Set mask blocks maskable interrupts
// - No interrupt right after mask is cleared
// - Negative flag follows result top bit
// - Zero flag set on all-zero result
// - Carry on add carry-out or subtract borrow
// - Shifts, rotates, bit branches update carry
// - One linear 16-bit address space
// - Moves encode separate source and destination modes
// - Test branches reach target relatively
// - Inherent mode makes no memory access
// - Relative offset sign-extended, added when taken
// - Wide immediate reads high byte first
// - Direct address gets zero high byte
// - Flag bits 6 and 5 read one
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module cfa_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cfa_pkg::cfa_axi_req_s axi_req,
	output var cfa_pkg::cfa_axi_rsp_s axi_rsp,
	input wire logic op_valid,
	input wire cfa_pkg::cfa_instr_s op,
	input wire logic irq_req,
	output var cfa_pkg::cfa_res_s res
);
	import cfa_pkg::*;

	typedef struct packed {
		logic [7:0] flags;
		cfa_res_s res;
		logic aw_got;
		logic [15:0] aw_addr;
		logic w_got;
		logic [7:0] w_byte;
		logic w_lane0;
		cfa_axi_rsp_s rsp;
	} cfa_state_s;

	cfa_state_s st_reg;
	cfa_state_s st_next;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] mode_len(input cfa_mode_e m, input logic wide);
		case (m)
			MODE_INHERENT: mode_len = 16'h0000;
			MODE_IMMEDIATE: mode_len = wide ? 16'h0002 : 16'h0001;
			default: mode_len = 16'h0001;
		endcase
	endfunction

	function automatic logic [15:0] mode_ea(input cfa_mode_e m, input logic [7:0] lo,
		input logic [15:0] pc);
		case (m)
			MODE_DIR: mode_ea = {DIRECT_PAGE, lo};
			MODE_IMMEDIATE: mode_ea = pc + 16'h0001;
			default: mode_ea = 16'h0000;
		endcase
	endfunction

	function automatic logic fix_check(input logic [7:0] f);
		fix_check = (f & FLAGS_ONES) == FLAGS_ONES;
	endfunction

	function automatic logic cond_true(input cfa_cond_e c, input logic [7:0] f);
		logic nv;
		nv = f[BIT_N] ^ f[BIT_V];
		case (c)
			COND_ALWAYS: cond_true = 1'b1;
			COND_EQ: cond_true = f[BIT_Z];
			COND_NE: cond_true = !f[BIT_Z];
			COND_GT: cond_true = !(f[BIT_Z] | nv);
			COND_GE: cond_true = !nv;
			COND_LE: cond_true = f[BIT_Z] | nv;
			COND_LT: cond_true = nv;
			COND_CC: cond_true = !f[BIT_C];
			COND_CS: cond_true = f[BIT_C];
			default: cond_true = 1'b0;
		endcase
	endfunction

	// ****************************************
	// Arithmetic
	// ****************************************
	logic cin;
	logic [8:0] sum;
	logic [8:0] dif;
	logic hi_fix;
	logic [7:0] corr;
	logic [8:0] adj_sum;
	logic [7:0] dec;
	logic [15:0] len;
	logic test_branch;

	assign cin = (op.op == OP_ADC || op.op == OP_SBC) ? st_reg.flags[BIT_C] : 1'b0;
	assign sum = {1'b0, op.a} + {1'b0, op.b} + {8'h00, cin};
	assign dif = {1'b0, op.a} - {1'b0, op.b} - {8'h00, cin};
	// Correction relies on the flags left by the prior add
	assign hi_fix = st_reg.flags[BIT_C] || (op.a > BCD_LIMIT);
	assign corr[7:4] = hi_fix ? BCD_FIX : 4'h0;
	assign corr[3:0] = (st_reg.flags[BIT_H] || op.a[3:0] > BCD_DIGIT_MAX) ? BCD_FIX : 4'h0;
	assign adj_sum = {1'b0, op.a} + {1'b0, corr};
	assign dec = op.a - 8'h01;
	assign test_branch = op.op == OP_BIT_BRANCH || op.op == OP_COMPARE_BRANCH
		|| op.op == OP_DECREMENT_BRANCH;
	// Offset byte follows operand bytes in test branches
	assign len = 16'h0001 + mode_len(op.src_mode, op.wide) + mode_len(op.dst_mode, 1'b0)
		+ {15'h0000, test_branch};

	// ****************************************
	// Next state
	// ****************************************
	logic [7:0] fl;
	logic [15:0] r;
	logic tk;

	always_comb begin
		st_next = st_reg;
		fl = st_reg.flags;
		r = st_reg.res.result;
		tk = 1'b0;
		st_next.res.done = 1'b0;
		st_next.res.irq_take = 1'b0;
		// Bus write lands first so a same-cycle instruction wins
		if (axi_req.awvalid && st_reg.rsp.awready) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st_reg.rsp.wready) begin
			st_next.w_got = 1'b1;
			st_next.w_byte = axi_req.wdata[7:0];
			st_next.w_lane0 = axi_req.wstrb[0];
		end
		if (st_reg.rsp.bvalid && axi_req.bready) begin
			st_next.rsp.bvalid = 1'b0;
		end
		if (st_next.aw_got && st_next.w_got && !st_reg.rsp.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.rsp.bvalid = 1'b1;
			st_next.rsp.bresp = RESP_SLVERR;
			if (st_next.aw_addr == ADDR_FLAGS) begin
				st_next.rsp.bresp = RESP_OKAY;
				if (st_next.w_lane0) begin
					fl = st_next.w_byte | FLAGS_ONES;
				end
			end
		end
		if (st_reg.rsp.rvalid && axi_req.rready) begin
			st_next.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && st_reg.rsp.arready) begin
			st_next.rsp.rvalid = 1'b1;
			st_next.rsp.rresp = RESP_OKAY;
			case (axi_req.araddr)
				ADDR_FLAGS: st_next.rsp.rdata = {24'h000000, st_reg.flags};
				ADDR_RESULT: st_next.rsp.rdata = {st_reg.res.ea, st_reg.res.result};
				ADDR_PC: st_next.rsp.rdata = {16'h0000, st_reg.res.pc_next};
				default: begin
					st_next.rsp.rdata = 32'h00000000;
					st_next.rsp.rresp = RESP_SLVERR;
				end
			endcase
		end
		st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
		st_next.rsp.wready = !st_next.w_got && !st_next.rsp.bvalid;
		st_next.rsp.arready = !st_next.rsp.rvalid;

		if (op_valid) begin
			// Flags not named in a case item stay as they were, except N and Z, which are set after the case for the result-producing ops but OP_DECREMENT_BRANCH
			case (op.op)
				OP_ADD, OP_ADC: begin
					r = {8'h00, sum[7:0]};
					fl[BIT_C] = sum[8];
					fl[BIT_H] = (op.a[3] & op.b[3]) | (op.b[3] & !r[3])
						| (!r[3] & op.a[3]);
					fl[BIT_V] = (op.a[7] == op.b[7]) && (r[7] != op.a[7]);
				end
				OP_SUB, OP_SBC: begin
					r = {8'h00, dif[7:0]};
					fl[BIT_C] = dif[8];
					fl[BIT_V] = (op.a[7] != op.b[7]) && (r[7] != op.a[7]);
				end
				OP_AND: begin
					r = {8'h00, op.a & op.b};
					fl[BIT_V] = 1'b0;
				end
				OP_LOAD: begin
					if (op.wide) begin
						// Immediate word arrives high byte first
						r = (op.src_mode == MODE_IMMEDIATE) ? {op.b1, op.b2}
							: op.d16;
					end else begin
						r = {8'h00, (op.src_mode == MODE_IMMEDIATE) ? op.b1 : op.a};
					end
					fl[BIT_V] = 1'b0;
				end
				OP_LSL: begin
					r = {8'h00, op.a[6:0], 1'b0};
					fl[BIT_C] = op.a[7];
					fl[BIT_V] = op.a[6] ^ op.a[7];
				end
				OP_ROR: begin
					r = {8'h00, st_reg.flags[BIT_C], op.a[7:1]};
					fl[BIT_C] = op.a[0];
					fl[BIT_V] = st_reg.flags[BIT_C] ^ op.a[0];
				end
				OP_DECIMAL_ADJUST: begin
					r = {8'h00, adj_sum[7:0]};
					fl[BIT_C] = hi_fix;
				end
				OP_MASK_CLEAR: fl[BIT_I] = 1'b0;
				OP_SEI: fl[BIT_I] = 1'b1;
				OP_TAP: fl = op.a | FLAGS_ONES;
				// Stacking is finished before this step is issued
				OP_INT_ENTRY: fl[BIT_I] = 1'b1;
				OP_BRANCH: tk = cond_true(op.cond, fl);
				OP_BIT_BRANCH: begin
					fl[BIT_C] = op.a[op.bitsel];
					tk = cond_true(op.cond, fl);
				end
				OP_COMPARE_BRANCH: tk = op.a == op.b;
				OP_DECREMENT_BRANCH: begin
					r = {8'h00, dec};
					tk = dec != 8'h00;
				end
				default: begin
				end
			endcase
			if (op.op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_LOAD, OP_LSL,
				OP_ROR, OP_DECIMAL_ADJUST}) begin
				fl[BIT_N] = (op.op == OP_LOAD && op.wide) ? r[15] : r[7];
				fl[BIT_Z] = (op.op == OP_LOAD && op.wide) ? (r == 16'h0000)
					: (r[7:0] == 8'h00);
			end
			st_next.res.done = 1'b1;
			st_next.res.result = r;
			st_next.res.taken = tk;
			st_next.res.ea = mode_ea(op.src_mode, op.b1, op.pc);
			st_next.res.dst_ea = mode_ea(op.dst_mode, op.b2, op.pc);
			st_next.res.mem_access = op.src_mode == MODE_DIR;
			// Offset is added only when the branch is taken
			st_next.res.pc_next = op.pc + len + (tk ? {{8{op.rel_off[7]}}, op.rel_off}
				: 16'h0000);
			// A mask that was set in the old flags blocks this boundary too
			st_next.res.irq_take = irq_req && !fl[BIT_I]
				&& !st_reg.flags[BIT_I];
		end
		st_next.flags = fl;
		st_next.res.flags = fl;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.flags <= FLAGS_RESET;
			st_reg.res.flags <= FLAGS_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign axi_rsp = st_reg.rsp;
	assign res = st_reg.res;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	flags_fixed_a: assert property (fix_check(res.flags))
		else $error("fixed flag bits not one");
	irq_mask_a: assert property (res.irq_take |-> !res.flags[BIT_I])
		else $error("interrupt taken while masked");
	irq_shadow_a: assert property (
		op_valid && op.op inside {OP_MASK_CLEAR, OP_TAP} && res.flags[BIT_I]
		|=> !res.irq_take)
		else $error("interrupt taken right after mask clear");
	entry_mask_a: assert property (
		op_valid && op.op == OP_INT_ENTRY |=> res.flags[BIT_I] && res.done)
		else $error("mask not set on interrupt entry");
	direct_page_a: assert property (
		op_valid && op.src_mode == MODE_DIR |=> res.ea == {8'h00, $past(op.b1)})
		else $error("direct address high byte not zero");
	rel_skip_a: assert property (
		op_valid && op.op == OP_BRANCH && op.cond == COND_NEVER
		&& op.src_mode == MODE_RELATIVE && op.dst_mode == MODE_INHERENT
		|=> res.pc_next == $past(op.pc) + 16'h0002 && !res.taken)
		else $error("untaken branch moved pc wrongly");
	add_carry_a: assert property (
		op_valid && op.op == OP_ADD |=>
		res.flags[BIT_C] == ((9'($past(op.a)) + 9'($past(op.b))) > 9'h0FF))
		else $error("add carry wrong");
	load_zero_a: assert property (
		op_valid && op.op == OP_LOAD && !op.wide && op.src_mode == MODE_DIR |=>
		res.flags[BIT_Z] == ($past(op.a) == 8'h00) && res.flags[BIT_N] == $past(op.a[7]))
		else $error("load zero or negative flag wrong");
	inh_nomem_a: assert property (
		op_valid && op.src_mode == MODE_INHERENT |=> !res.mem_access)
		else $error("inherent op accessed memory");
	and_keep_a: assert property (
		op_valid && op.op == OP_AND |=> $stable(res.flags[BIT_C]) && $stable(res.flags[BIT_H]))
		else $error("logic op changed carry or half carry");
endmodule
`default_nettype wire

// *** design/cfa_pkg.sv ***
// Constants, enumerations and carriers for the flags and addressing unit.
// Assumes one 25 MHz clock and an AXI4-Lite master with 16-bit addresses.
`default_nettype none
package cfa_pkg;
	// ****************************************
	// Register map and bus answers
	// ****************************************
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_FLAGS = 16'h0000;
	localparam logic [15:0] ADDR_RESULT = 16'h0004;
	localparam logic [15:0] ADDR_PC = 16'h0008;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Flag layout
	// ****************************************
	localparam int BIT_V = 7;
	localparam int BIT_H = 4;
	localparam int BIT_I = 3;
	localparam int BIT_N = 2;
	localparam int BIT_Z = 1;
	localparam int BIT_C = 0;
	localparam logic [7:0] FLAGS_ONES = 8'h60;
	localparam logic [7:0] FLAGS_RESET = 8'h68;
	localparam logic [7:0] DIRECT_PAGE = 8'h00;
	localparam logic [7:0] BCD_LIMIT = 8'h99;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [3:0] BCD_FIX = 4'h6;
	// ****************************************
	// Operations and modes
	// ****************************************
	typedef enum logic [1:0] {MODE_INHERENT, MODE_RELATIVE, MODE_IMMEDIATE,
		MODE_DIR} cfa_mode_e;
	typedef enum logic [4:0] {OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_LOAD,
		OP_LSL, OP_ROR, OP_DECIMAL_ADJUST, OP_MASK_CLEAR, OP_SEI, OP_TAP, OP_INT_ENTRY,
		OP_BRANCH, OP_BIT_BRANCH, OP_COMPARE_BRANCH, OP_DECREMENT_BRANCH} cfa_op_e;
	typedef enum logic [3:0] {COND_ALWAYS, COND_NEVER, COND_EQ, COND_NE, COND_GT,
		COND_GE, COND_LE, COND_LT, COND_CC, COND_CS} cfa_cond_e;
	typedef struct packed {
		cfa_op_e op;
		cfa_cond_e cond;
		cfa_mode_e src_mode;
		cfa_mode_e dst_mode;
		logic wide;
		logic [2:0] bitsel;
		logic [7:0] a;
		logic [7:0] b;
		logic [15:0] d16;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] rel_off;
		logic [15:0] pc;
	} cfa_instr_s;
	typedef struct packed {
		logic done;
		logic [15:0] result;
		logic [15:0] ea;
		logic [15:0] dst_ea;
		logic mem_access;
		logic [15:0] pc_next;
		logic taken;
		logic irq_take;
		logic [7:0] flags;
	} cfa_res_s;
	typedef struct packed {
		logic awvalid;
		logic [15:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [15:0] araddr;
		logic rready;
	} cfa_axi_req_s;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cfa_axi_rsp_s;
endpackage
`default_nettype wire

// *** tb/cfa_mem_model.sv ***
// Byte image of the unified 16-bit address space, read combinationally.
// Assumes the bench presents an address and samples data in the same cycle.
`default_nettype none
module cfa_mem_model (
	input wire logic [15:0] addr,
	output logic [7:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Contents
	// ****************************************
	// Pattern, not storage: a 64 KB array would dwarf the bench
	always_comb data = addr[15:8] ^ addr[7:0];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the flags and operand addressing unit.
// Assumes cfa_pkg and cfa_core are compiled first; one 25 MHz clock.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import cfa_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	typedef struct packed {
		cfa_op_e op;
		logic [7:0] fin, a, b, res, fout;
	} cfa_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic op_valid = 1'b0;
	logic irq_req = 1'b0;
	cfa_axi_req_s req = '0;
	cfa_axi_rsp_s rsp;
	cfa_instr_s ins = '0;
	cfa_res_s res;
	logic [15:0] fetch_pc = '0;
	logic [7:0] b_hi, b_lo, rd;
	logic [1:0] resp;
	int miscompares = 0;
	int compares = 0;
	cfa_row_s rows [13] = '{
		'{OP_ADD, 8'h60, 8'h7F, 8'h01, 8'h80, 8'hF4},
		'{OP_ADD, 8'h60, 8'hFF, 8'h01, 8'h00, 8'h73},
		'{OP_ADC, 8'h61, 8'h08, 8'h08, 8'h11, 8'h70},
		'{OP_SUB, 8'h70, 8'h00, 8'h01, 8'hFF, 8'h75},
		'{OP_SUB, 8'h60, 8'h80, 8'h01, 8'h7F, 8'hE0},
		'{OP_AND, 8'hE0, 8'hF0, 8'h0F, 8'h00, 8'h62},
		'{OP_LSL, 8'h60, 8'h80, 8'h00, 8'h00, 8'hE3},
		'{OP_DECIMAL_ADJUST, 8'h60, 8'h9A, 8'h00, 8'h00, 8'h63},
		'{OP_ROR, 8'h61, 8'h02, 8'h00, 8'h81, 8'hE4},
		'{OP_SBC, 8'h61, 8'h10, 8'h0F, 8'h00, 8'h62},
		'{OP_SEI, 8'h60, 8'h00, 8'h00, 8'h00, 8'h68},
		'{OP_TAP, 8'h68, 8'h83, 8'h00, 8'h00, 8'hE3},
		'{OP_LOAD, 8'hE0, 8'h80, 8'h00, 8'h80, 8'h64}};
	cfa_core u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.op_valid(op_valid), .op(ins), .irq_req(irq_req), .res(res));
	cfa_mem_model u_mem_hi (.addr(fetch_pc + 16'h0001), .data(b_hi));
	cfa_mem_model u_mem_lo (.addr(fetch_pc + 16'h0002), .data(b_lo));
	always #20 aclk = ~aclk;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic give_verdict();
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic bound(input int n);
		if (n >= 40) begin
			chk(16'h0000, 16'h0001);
			give_verdict();
		end
	endtask
	task automatic axi_wr(input logic [15:0] ad, input logic [7:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= ad;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'h1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 40);
		bound(n);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [15:0] ad, output logic [7:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= ad;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 40);
		bound(n);
		d = rsp.rdata[7:0];
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	task automatic do_op(input cfa_instr_s i);
		@(posedge aclk);
		op_valid <= 1'b1;
		ins <= i;
		@(posedge aclk);
		op_valid <= 1'b0;
		#1;
		chk(16'(res.done), 16'h0001);
	endtask
	function automatic cfa_instr_s mk(input cfa_op_e o, input logic [7:0] a);
		cfa_instr_s i;
		i = '0;
		i.op = o;
		i.a = a;
		return i;
	endfunction
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		cfa_instr_s i;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk(16'(res.flags), 16'(FLAGS_RESET));
		axi_wr(ADDR_FLAGS, 8'h00, resp);
		axi_rd(ADDR_FLAGS, rd, resp);
		chk(16'(rd), 16'h0060);
		axi_wr(ADDR_RESULT, 8'hFF, resp);
		chk(16'(resp), 16'(RESP_SLVERR));
		axi_rd(16'h0010, rd, resp);
		chk(16'(resp), 16'(RESP_SLVERR));
		$display("Case registers over");
		foreach (rows[k]) begin
			axi_wr(ADDR_FLAGS, rows[k].fin, resp);
			i = mk(rows[k].op, rows[k].a);
			i.b = rows[k].b;
			do_op(i);
			chk(16'(res.result[7:0]), 16'(rows[k].res));
			chk(16'(res.flags), 16'(rows[k].fout));
			chk(16'(res.mem_access), 16'h0000);
		end
		$display("Case rows over");
		// Shadow only holds with the mask set before the clear
		axi_wr(ADDR_FLAGS, 8'h68, resp);
		irq_req <= 1'b1;
		do_op(mk(OP_MASK_CLEAR, 8'h00));
		chk(16'(res.irq_take), 16'h0000);
		do_op(mk(OP_NOP, 8'h00));
		chk(16'(res.irq_take), 16'h0001);
		do_op(mk(OP_INT_ENTRY, 8'h00));
		chk(16'(res.flags[BIT_I]), 16'h0001);
		do_op(mk(OP_NOP, 8'h00));
		chk(16'(res.irq_take), 16'h0000);
		do_op(mk(OP_TAP, 8'h00));
		chk(16'(res.irq_take), 16'h0000);
		chk(16'(res.flags), 16'h0060);
		do_op(mk(OP_NOP, 8'h00));
		chk(16'(res.irq_take), 16'h0001);
		irq_req <= 1'b0;
		$display("Case mask over");
		for (int k = 0; k < 3; k++) begin
			axi_wr(ADDR_FLAGS, (k == 1) ? 8'hE4 : 8'h64, resp);
			i = mk(OP_BRANCH, 8'h00);
			i.cond = (k == 2) ? COND_NEVER : COND_LT;
			i.src_mode = MODE_RELATIVE;
			i.rel_off = 8'hFC;
			i.pc = 16'h1000;
			do_op(i);
			chk(16'(res.taken), (k == 0) ? 16'h0001 : 16'h0000);
			chk(res.pc_next, (k == 0) ? 16'h0FFE : 16'h1002);
		end
		axi_wr(ADDR_FLAGS, 8'h60, resp);
		i = mk(OP_BIT_BRANCH, 8'h08);
		i.cond = COND_CS;
		i.src_mode = MODE_DIR;
		i.dst_mode = MODE_DIR;
		i.bitsel = 3'h3;
		i.b1 = 8'h80;
		i.b2 = 8'h20;
		i.rel_off = 8'h10;
		i.pc = 16'h2000;
		do_op(i);
		chk(16'(res.flags[BIT_C]), 16'h0001);
		chk(res.pc_next, 16'h2014);
		chk(res.ea, 16'h0080);
		chk(res.dst_ea, 16'h0020);
		chk(16'(res.mem_access), 16'h0001);
		axi_rd(ADDR_PC, rd, resp);
		chk(16'(rd), 16'h0014);
		i = mk(OP_COMPARE_BRANCH, 8'h55);
		i.b = 8'h55;
		i.src_mode = MODE_IMMEDIATE;
		i.b1 = 8'h55;
		i.rel_off = 8'h05;
		i.pc = 16'h3000;
		do_op(i);
		chk(16'(res.taken), 16'h0001);
		chk(res.pc_next, 16'h3008);
		i = mk(OP_DECREMENT_BRANCH, 8'h01);
		i.rel_off = 8'h05;
		i.pc = 16'h3000;
		do_op(i);
		chk(res.result, 16'h0000);
		chk(res.pc_next, 16'h3002);
		$display("Case branches over");
		fetch_pc <= 16'h8000;
		#1;
		i = mk(OP_LOAD, 8'h00);
		i.wide = 1'b1;
		i.src_mode = MODE_IMMEDIATE;
		i.b1 = b_hi;
		i.b2 = b_lo;
		i.pc = fetch_pc;
		do_op(i);
		chk(res.result, {b_hi, b_lo});
		chk(16'(res.flags[BIT_N]), 16'(b_hi[7]));
		chk(res.ea, 16'h8001);
		chk(res.pc_next, 16'h8003);
		i = mk(OP_LOAD, 8'h00);
		i.src_mode = MODE_DIR;
		i.b1 = 8'h40;
		do_op(i);
		chk(16'(res.flags[BIT_Z]), 16'h0001);
		chk(res.ea, 16'h0040);
		i.wide = 1'b1;
		i.d16 = 16'h8000;
		do_op(i);
		chk(res.result, 16'h8000);
		chk(16'(res.flags[BIT_N]), 16'h0001);
		chk(16'(res.flags[BIT_Z]), 16'h0000);
		$display("Case load over");
		// Mid-run reset must restore the mask and the fixed ones
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		chk(16'(res.flags), 16'(FLAGS_RESET));
		chk(16'(rsp.awready), 16'h0000);
		@(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk(16'(rsp.arready), 16'h0000);
		axi_rd(ADDR_FLAGS, rd, resp);
		chk(16'(rd), 16'(FLAGS_RESET));
		$display("Case reset over");
		give_verdict();
	end
endmodule
`default_nettype wire
